// [sdsr_consts.svh]
/*
  Constants of the segment display sync register slice: offsets, bit positions, reset values, timing.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef SDSR_CONSTS_SVH
`define SDSR_CONSTS_SVH

`define SDSR_OFS_W 12
`define SDSR_OFS_SEG_HIGH_THREE 12'h05c
`define SDSR_OFS_UPDATE_FREEZE 12'h060
`define SDSR_OFS_SYNC_BUSY 12'h064
`define SDSR_WORD_W 32

`define SDSR_SEG_MSB 7
`define SDSR_SEG_RESET 8'h00
`define SDSR_FREEZE_BIT 0
`define SDSR_FREEZE_RESET 1'b0
`define SDSR_BUSY_W 12
`define SDSR_BUSY_SEG_HIGH_THREE 11
`define SDSR_BUSY_OTHER_W 11
`define SDSR_BUSY_RESET 12'h000

`define SDSR_CLK_PERIOD_NS 50
`define SDSR_SYNC_TIME_NS 91553
`define SDSR_SYNC_CYCLES ((`SDSR_SYNC_TIME_NS + `SDSR_CLK_PERIOD_NS - 1) / `SDSR_CLK_PERIOD_NS)

`define SDSR_HTRANS_NONSEQ_BIT 1
`define SDSR_HRESP_OKAY 1'b0

`endif

// [sdsr_pkg.sv]
/*
  Types shared by the segment display sync register slice.
  Assumes sdsr_consts.svh is on the include path.
*/
`include "sdsr_consts.svh"

package sdsr_pkg;
  typedef logic [`SDSR_SEG_MSB:0] sdsr_seg_t;
  typedef logic [`SDSR_BUSY_W-1:0] sdsr_busy_t;
  typedef logic [`SDSR_BUSY_OTHER_W-1:0] sdsr_other_t;
  typedef logic [31:0] sdsr_word_t;
endpackage

// [sdsr_sync_chan.sv]
/*
  One synchronization tracker: busy from a write until the value counts as crossed.
  Assumes a single clock and a one-cycle start pulse.
*/
`timescale 1ns/1ps

module sdsr_sync_chan #(
  parameter int CNT_W = 13,
  parameter int CYCLES = 1832
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  output logic busy,
  output logic done
);
  logic [CNT_W-1:0] cnt_q;
  logic done_q;

  // Counter must hold the whole crossing count
  if (CNT_W < 1 || CNT_W > 30 || CYCLES < 1 || CYCLES >= (1 << CNT_W)) begin : g_chk
    $error("CYCLES does not fit the counter");
  end

  // A new write restarts the wait, so the newest value is what crosses
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (start) begin
      cnt_q <= CNT_W'(CYCLES);
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == CNT_W'(1)) && !start;
    end
  end

  assign busy = (cnt_q != '0);
  assign done = done_q;
endmodule // sdsr_sync_chan

// [sdsr_regs.sv]
/*
  AHB-Lite slave for the high segment register of line three, the update freeze bit and the busy flags.
  Assumes one AHB-Lite master, word transfers, and write pulses from the unit's other registers.
*/
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "sdsr_consts.svh"

module sdsr_regs #(
  parameter int SYNC_CYCLES = `SDSR_SYNC_CYCLES,
  parameter int CNT_W = 13
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire sdsr_pkg::sdsr_word_t hwdata,
  input wire sdsr_pkg::sdsr_other_t other_write,
  output sdsr_pkg::sdsr_word_t hrdata,
  output logic hreadyout,
  output logic hresp,
  output sdsr_pkg::sdsr_seg_t disp_seg_high_line_three,
  output logic disp_update,
  output logic update_hold
);
  import sdsr_pkg::*;

  // Counter must hold the full crossing count
  if (CNT_W < 1 || CNT_W > 30) begin : g_chk_w
    $error("CNT_W out of range");
  end

  if (SYNC_CYCLES < 1 || SYNC_CYCLES >= (1 << CNT_W)) begin : g_chk
    $error("SYNC_CYCLES does not fit the counter");
  end

  // One own channel on top of the other registers' pulses
  if (`SDSR_BUSY_W != `SDSR_BUSY_OTHER_W + 1) begin : g_chk_busy
    $error("busy vector width does not match its sources");
  end

  if (`SDSR_BUSY_SEG_HIGH_THREE != `SDSR_BUSY_W - 1) begin : g_chk_pos
    $error("own busy bit must be the top bit");
  end

  logic acc;
  logic wr_pend_q;
  logic [`SDSR_OFS_W-1:0] wr_addr_q;
  logic [`SDSR_OFS_W-1:0] ofs;
  logic wr_seg;
  logic wr_freeze;
  sdsr_seg_t seg_q;
  sdsr_seg_t seg_view;
  sdsr_seg_t staged_q;
  sdsr_seg_t disp_q;
  logic freeze_q;
  logic freeze_view;
  logic pending_q;
  logic apply;
  logic disp_update_q;
  sdsr_busy_t start_vec;
  sdsr_busy_t busy_vec;
  sdsr_busy_t done_vec;
  sdsr_busy_t busy_view;
  sdsr_word_t hrdata_q;
  logic hreadyout_q;
  logic hresp_q;
  sdsr_word_t hrdata_d;
  sdsr_word_t seg_word;
  sdsr_word_t freeze_word;
  sdsr_word_t busy_word;
  logic wr_take;
  logic rd_take;

  // hsize is accepted but every access acts on the whole word
  assign acc = hsel && htrans[`SDSR_HTRANS_NONSEQ_BIT] && hready;
  assign wr_take = acc && hwrite;
  assign rd_take = acc && !hwrite;
  assign ofs = haddr[`SDSR_OFS_W-1:0];
  assign wr_seg = wr_pend_q && (wr_addr_q == `SDSR_OFS_SEG_HIGH_THREE);
  assign wr_freeze = wr_pend_q && (wr_addr_q == `SDSR_OFS_UPDATE_FREEZE);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
    end else begin
      wr_pend_q <= wr_take;
    end
  end

  // Address kept only for the data phase that follows
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_addr_q <= '0;
    end else if (wr_take) begin
      wr_addr_q <= ofs;
    end
  end

  // Reserved upper bits are dropped on write; software keeps them zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_q <= `SDSR_SEG_RESET;
    end else if (wr_seg) begin
      seg_q <= hwdata[`SDSR_SEG_MSB:0];
    end
  end

  // Freeze gates only the apply step; crossings still finish
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      freeze_q <= `SDSR_FREEZE_RESET;
    end else if (wr_freeze) begin
      freeze_q <= hwdata[`SDSR_FREEZE_BIT];
    end
  end

  // Own register starts bit 11; the rest come from the unit's other registers
  assign start_vec = {wr_seg, other_write};

  for (genvar i = 0; i < `SDSR_BUSY_W; i++) begin : g_chan
    sdsr_sync_chan #(
      .CNT_W(CNT_W),
      .CYCLES(SYNC_CYCLES)
    ) u_chan (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(start_vec[i]),
      .busy(busy_vec[i]),
      .done(done_vec[i])
    );
  end

  // Value captured at the end of the crossing, not at the write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      staged_q <= `SDSR_SEG_RESET;
    end else if (done_vec[`SDSR_BUSY_SEG_HIGH_THREE]) begin
      staged_q <= seg_q;
    end
  end

  // New arrival wins over the clear of the pending flag
  assign apply = pending_q && !freeze_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pending_q <= 1'b0;
    end else begin
      pending_q <= (pending_q && !apply) || (|done_vec);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_q <= `SDSR_SEG_RESET;
    end else if (apply) begin
      disp_q <= staged_q;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      disp_update_q <= 1'b0;
    end else begin
      disp_update_q <= apply;
    end
  end

  // Forward a write still in its data phase so back to back reads see it
  assign seg_view = wr_seg ? hwdata[`SDSR_SEG_MSB:0] : seg_q;
  assign freeze_view = wr_freeze ? hwdata[`SDSR_FREEZE_BIT] : freeze_q;
  assign busy_view = busy_vec | start_vec;

  assign seg_word = {{(`SDSR_WORD_W - `SDSR_SEG_MSB - 1){1'b0}}, seg_view};
  assign freeze_word = {{(`SDSR_WORD_W - 1){1'b0}}, freeze_view};
  assign busy_word = {{(`SDSR_WORD_W - `SDSR_BUSY_W){1'b0}}, busy_view};

  // Unmapped offsets and reserved bits read as zero
  always_comb begin
    hrdata_d = '0;
    if (rd_take) begin
      case (ofs)
        `SDSR_OFS_SEG_HIGH_THREE: hrdata_d = seg_word;
        `SDSR_OFS_UPDATE_FREEZE: hrdata_d = freeze_word;
        `SDSR_OFS_SYNC_BUSY: hrdata_d = busy_word;
        default: hrdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= '0;
    end else begin
      hrdata_q <= hrdata_d;
    end
  end

  // Zero wait states; every answer is OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_q <= `SDSR_HRESP_OKAY;
    end else begin
      hresp_q <= `SDSR_HRESP_OKAY;
    end
  end

  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = hresp_q;
  assign disp_seg_high_line_three = disp_q;
  assign disp_update = disp_update_q;
  assign update_hold = freeze_q;
endmodule // sdsr_regs

// [sdsr_regs_dummy_guard.sv]
/*
  Holds no logic; the register slice lives in sdsr_regs.sv and sdsr_sync_chan.sv.
  Assumes nothing of its surroundings.
*/

// [sdsr_regs_properties.sv]
/* Port checker of the register slice.
   Bound to sdsr_regs, zero wait states. */
`timescale 1ns/1ps
module sdsr_regs_chk
  import sdsr_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire sdsr_pkg::sdsr_word_t hwdata,
  input wire sdsr_pkg::sdsr_word_t hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire sdsr_pkg::sdsr_seg_t disp_seg_high_line_three,
  input wire logic disp_update,
  input wire logic update_hold
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take(logic [11:0] a, logic w);
    hsel && htrans[1] && hready && hwrite == w && haddr[11:0] == a;
  endsequence
  property p_top; hrdata[31:12] == '0; endproperty
  property p_seg_rd; s_take(12'h05c, 1'b0) |=> hrdata[31:8] == '0; endproperty
  property p_frz_rd; s_take(12'h060, 1'b0) |=> hrdata[31:1] == '0; endproperty
  property p_idle; !(hsel && htrans[1] && hready && !hwrite) |=> hrdata == '0; endproperty
  property p_chg; $changed(disp_seg_high_line_three) |-> disp_update; endproperty
  property p_hold; update_hold && $past(update_hold) |-> !disp_update; endproperty
  property p_hold_set; s_take(12'h060, 1'b1) ##1 hwdata[0] |-> ##[1:2] update_hold; endproperty
  property p_hold_clr; s_take(12'h060, 1'b1) ##1 !hwdata[0] |-> ##[1:2] !update_hold; endproperty
  property p_okay; hreadyout && !hresp; endproperty
  a_top: assert property (p_top) else $error("reserved read bits set");
  a_seg_rd: assert property (p_seg_rd) else $error("segment reserved bits");
  a_frz_rd: assert property (p_frz_rd) else $error("freeze reserved bits");
  a_idle: assert property (p_idle) else $error("read data outside read");
  a_chg: assert property (p_chg) else $error("display changed without update");
  a_hold: assert property (p_hold) else $error("update while frozen");
  a_hold_set: assert property (p_hold_set) else $error("freeze not set");
  a_hold_clr: assert property (p_hold_clr) else $error("freeze not cleared");
  a_okay: assert property (p_okay) else $error("wait state or error response");
endmodule // sdsr_regs_chk

bind sdsr_regs sdsr_regs_chk u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata,
  .hrdata, .hreadyout, .hresp, .disp_seg_high_line_three, .disp_update, .update_hold);

// [sdsr_regs_tb_top.sv]
/* Self-checking bench of the register slice over AHB-Lite.
   Assumes a short sync count; polls hready anyway. */
`timescale 1ns/1ps
module sdsr_regs_tb_top;
  import sdsr_pkg::*;
  localparam int SYNC = 8;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = '0;
  sdsr_word_t hwdata = '0, hrdata, rv;
  sdsr_other_t other_write = '0;
  sdsr_seg_t disp;
  logic hreadyout, hresp, disp_update, update_hold;
  int miscompares = 0, n_checks = 0;
  sdsr_regs #(.SYNC_CYCLES(SYNC)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .other_write, .hrdata, .hreadyout, .hresp,
    .disp_seg_high_line_three(disp), .disp_update, .update_hold);
  initial forever #25 hclk = ~hclk;
  task automatic chk(input sdsr_word_t seen, input sdsr_word_t exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Single word transfer, master side
  task automatic xfer(input logic [11:0] a, input logic w, input sdsr_word_t d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rv = hrdata;
  endtask
  task automatic rd_chk(input logic [11:0] a, input sdsr_word_t exp);
    xfer(a, 1'b0, '0);
    chk(rv, exp);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Far above the expected run, so only a hang trips it
  initial begin
    repeat (3000) @(posedge hclk);
    miscompares++;
    summarize;
  end
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(12'h05c, 32'h0);
    rd_chk(12'h060, 32'h0);
    rd_chk(12'h064, 32'h0);
    xfer(12'h05c, 1'b1, 32'ha5);
    rd_chk(12'h064, 32'h800);
    rd_chk(12'h05c, 32'ha5);
    repeat (SYNC + 4) @(posedge hclk);
    chk({24'h0, disp}, 32'ha5);
    rd_chk(12'h064, 32'h0);
    xfer(12'h060, 1'b1, 32'h1);
    xfer(12'h05c, 1'b1, 32'h3c);
    repeat (SYNC + 4) @(posedge hclk);
    chk({24'h0, disp}, 32'ha5);
    rd_chk(12'h060, 32'h1);
    xfer(12'h060, 1'b1, 32'h0);
    repeat (4) @(posedge hclk);
    chk({24'h0, disp}, 32'h3c);
    // Reset in mid crossing with freeze set and a new value pending
    xfer(12'h060, 1'b1, 32'h1);
    xfer(12'h05c, 1'b1, 32'h5a);
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    chk({24'h0, disp}, 32'h0);
    rd_chk(12'h05c, 32'h0);
    rd_chk(12'h060, 32'h0);
    rd_chk(12'h064, 32'h0);
    xfer(12'h064, 1'b1, 32'hfff);
    rd_chk(12'h064, 32'h0);
    rd_chk(12'h068, 32'h0);
    for (int i = 0; i < 11; i++) begin
      @(posedge hclk);
      other_write <= sdsr_other_t'(1) << i;
      @(posedge hclk);
      other_write <= '0;
      rd_chk(12'h064, 32'h1 << i);
      repeat (SYNC) @(posedge hclk);
      rd_chk(12'h064, 32'h0);
    end
    summarize;
  end
endmodule // sdsr_regs_tb_top
